// file: hdl/dtr_regs.v
// Tone control and run registers of the audio decoder, seen by the host
// through the chip's byte-wide control register port.
// Assumes the serial control bus engine, the decoder core and the software
// reset all run on clk_i, so no input needs a synchroniser.
//
// Notes on behaviour
// - Read-only stream bitrate byte, 1 kbit/s units.
// - Firmware version readable at 0x71 after boot.
// - Writing run bit starts decoding; resets clear.
// - Treble corner: 16-bit Hz, high:low bytes.
// - Bass corner: 16-bit Hz, high:low bytes.
// - Treble gain signed, 1.5 dB per unit.
// - Bass gain signed, 1.5 dB per unit.
// - Gains limited to plus or minus 18 dB.
// - Headroom byte attenuates 1.5 dB per unit.
// - Both resets clear all these registers.
`timescale 1ns/1ps
`include "dtr_map.vh"

module dtr_regs (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        soft_rst_i,
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_rd_i,
    output wire [7:0]  reg_rdata_o,
    output wire        reg_hit_o,
    input  wire        rate_upd_i,
    input  wire [7:0]  rate_kbps_i,
    input  wire        boot_done_i,
    input  wire [7:0]  fw_code_i,
    output wire        decode_run_o,
    output wire [15:0] treble_corner_o,
    output wire [15:0] bass_corner_o,
    output wire [4:0]  treble_step_o,
    output wire [4:0]  bass_step_o,
    output wire [4:0]  headroom_step_o
);

    // ------------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------------
    reg  [7:0] mean_rate_reg;               // Average stream rate, kbit/s.
    reg  [7:0] fw_version_reg;              // Version caught at boot end.
    reg        decode_go_reg;               // Run flag.
    reg  [7:0] hi_corner_lo_reg;            // Treble corner, low byte.
    reg  [7:0] hi_corner_hi_reg;            // Treble corner, high byte.
    reg  [7:0] lo_corner_lo_reg;            // Bass corner, low byte.
    reg  [7:0] lo_corner_hi_reg;            // Bass corner, high byte.
    reg  [7:0] hi_gain_reg;                 // Treble gain code as written.
    reg  [7:0] lo_gain_reg;                 // Bass gain code as written.
    reg  [7:0] headroom_reg;                // Headroom code as written.
    reg  [7:0] rdata_reg;                   // Read data to the port.
    reg  [7:0] rdata_next;                  // Read multiplexer output.
    reg        hit_next;                    // Address is a mapped register.
    wire       clr;                         // Either reset.

    assign clr = !rstn_i || soft_rst_i;

    // ------------------------------------------------------------------------
    // Core-fed read-only registers.
    // ------------------------------------------------------------------------

    // The bitrate byte is loaded by the decoder core only; host writes to it
    // are dropped because the register is read-only.
    always @(posedge clk_i) begin
        if (clr) begin
            mean_rate_reg <= `DTR_RST_BYTE;
        end else if (rate_upd_i) begin
            mean_rate_reg <= rate_kbps_i;
        end
    end

    // The version code is caught when boot finishes; until then, and after
    // any reset, the location reads zero, which is a reboot in progress.
    always @(posedge clk_i) begin
        if (clr) begin
            fw_version_reg <= `DTR_RST_BYTE;
        end else if (boot_done_i) begin
            fw_version_reg <= fw_code_i;
        end
    end

    // ------------------------------------------------------------------------
    // Host-written registers.
    // ------------------------------------------------------------------------

    // Every writable byte is updated on the cycle of its write strobe. Reset
    // wins over a write in the same cycle.
    always @(posedge clk_i) begin
        if (clr) begin
            decode_go_reg    <= 1'b0;
            hi_corner_lo_reg <= `DTR_RST_BYTE;
            hi_corner_hi_reg <= `DTR_RST_BYTE;
            lo_corner_lo_reg <= `DTR_RST_BYTE;
            lo_corner_hi_reg <= `DTR_RST_BYTE;
            hi_gain_reg      <= `DTR_RST_BYTE;
            lo_gain_reg      <= `DTR_RST_BYTE;
            headroom_reg     <= `DTR_RST_BYTE;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `DTR_ADDR_DECODE_GO: begin
                    // Only bit 0 is kept; the rest of the byte is ignored.
                    decode_go_reg <= reg_wdata_i[`DTR_RUN_BIT];
                end
                `DTR_ADDR_HI_CORNER_LO: begin
                    hi_corner_lo_reg <= reg_wdata_i;
                end
                `DTR_ADDR_HI_CORNER_HI: begin
                    hi_corner_hi_reg <= reg_wdata_i;
                end
                `DTR_ADDR_LO_CORNER_LO: begin
                    lo_corner_lo_reg <= reg_wdata_i;
                end
                `DTR_ADDR_LO_CORNER_HI: begin
                    lo_corner_hi_reg <= reg_wdata_i;
                end
                `DTR_ADDR_HI_GAIN: begin
                    hi_gain_reg <= reg_wdata_i;
                end
                `DTR_ADDR_LO_GAIN: begin
                    lo_gain_reg <= reg_wdata_i;
                end
                `DTR_ADDR_HEADROOM: begin
                    headroom_reg <= reg_wdata_i;
                end
                default: begin
                    // Read-only and unmapped offsets ignore writes.
                    decode_go_reg <= decode_go_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------------------

    // Gain bytes read back exactly as written so the host can verify its own
    // programming; the clamp acts only on what the filter is given.
    always @* begin
        rdata_next = `DTR_RST_BYTE;
        hit_next   = 1'b1;
        case (reg_addr_i)
            `DTR_ADDR_MEAN_RATE: begin
                rdata_next = mean_rate_reg;
            end
            `DTR_ADDR_FW_VERSION: begin
                rdata_next = fw_version_reg;
            end
            `DTR_ADDR_DECODE_GO: begin
                rdata_next[`DTR_RUN_BIT] = decode_go_reg;
            end
            `DTR_ADDR_HI_CORNER_LO: begin
                rdata_next = hi_corner_lo_reg;
            end
            `DTR_ADDR_HI_CORNER_HI: begin
                rdata_next = hi_corner_hi_reg;
            end
            `DTR_ADDR_LO_CORNER_LO: begin
                rdata_next = lo_corner_lo_reg;
            end
            `DTR_ADDR_LO_CORNER_HI: begin
                rdata_next = lo_corner_hi_reg;
            end
            `DTR_ADDR_HI_GAIN: begin
                rdata_next = hi_gain_reg;
            end
            `DTR_ADDR_LO_GAIN: begin
                rdata_next = lo_gain_reg;
            end
            `DTR_ADDR_HEADROOM: begin
                rdata_next = headroom_reg;
            end
            default: begin
                // Unmapped offsets read as zero and flag no hit.
                hit_next = 1'b0;
            end
        endcase
    end

    // Read data is captured on the read strobe and held until the next read,
    // so the serial engine may shift it out at its own pace.
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_reg <= `DTR_RST_BYTE;
        end else if (reg_rd_i) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign reg_hit_o   = hit_next;

    // ------------------------------------------------------------------------
    // Settings handed to the decoder and tone filter.
    // ------------------------------------------------------------------------

    // Corner bytes join high over low into one frequency word in hertz.
    assign treble_corner_o = {hi_corner_hi_reg, hi_corner_lo_reg};
    assign bass_corner_o   = {lo_corner_hi_reg, lo_corner_lo_reg};
    assign decode_run_o    = decode_go_reg;

    // Treble gain: signed steps of 1.5 dB, clamped to twelve steps each way.
    dtr_gain_sat #(
        .SIGNED_CODE (1)
    ) u_treble_sat (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .soft_rst_i (soft_rst_i),
        .code_i     (hi_gain_reg),
        .step_o     (treble_step_o)
    );

    // Bass gain: same law as treble.
    dtr_gain_sat #(
        .SIGNED_CODE (1)
    ) u_bass_sat (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .soft_rst_i (soft_rst_i),
        .code_i     (lo_gain_reg),
        .step_o     (bass_step_o)
    );

    // Headroom: unsigned steps of 1.5 dB cut, limited at twelve (18 dB).
    dtr_gain_sat #(
        .SIGNED_CODE (0)
    ) u_headroom_sat (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .soft_rst_i (soft_rst_i),
        .code_i     (headroom_reg),
        .step_o     (headroom_step_o)
    );

endmodule

// file: common/dtr_map.vh
// Address map, reset values and limits of the decoder tone and run registers.
// Assumes it is included by bare name from the design files under hdl/.
`ifndef DTR_MAP_VH
`define DTR_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the control register port.
// ----------------------------------------------------------------------------
`define DTR_ADDR_MEAN_RATE      8'h6A
`define DTR_ADDR_FW_VERSION     8'h71
`define DTR_ADDR_DECODE_GO      8'h72
`define DTR_ADDR_HI_CORNER_LO   8'h77
`define DTR_ADDR_HI_CORNER_HI   8'h78
`define DTR_ADDR_LO_CORNER_LO   8'h79
`define DTR_ADDR_LO_CORNER_HI   8'h7A
`define DTR_ADDR_HI_GAIN        8'h7B
`define DTR_ADDR_LO_GAIN        8'h7C
`define DTR_ADDR_HEADROOM       8'h7D

// ----------------------------------------------------------------------------
// Reset values, field positions and limits.
// ----------------------------------------------------------------------------
`define DTR_RST_BYTE            8'h00
`define DTR_RST_STEP            5'h00
`define DTR_RST_WORD            16'h0000
`define DTR_RUN_BIT             0
`define DTR_STEP_MSB            4
`define DTR_GAIN_POS_MAX        8'h0C
`define DTR_GAIN_NEG_MIN        8'hF4
`define DTR_SIGN_BIT            7

`endif

// file: hdl/dtr_gain_sat.v
// Clamps one tone gain or headroom code to the allowed step range and holds
// the clamped step count in a flip-flop.
// Assumes both resets come from logic on clk_i, already synchronous.
`timescale 1ns/1ps
`include "dtr_map.vh"

module dtr_gain_sat #(
    parameter SIGNED_CODE = 1               // 1: two's complement, 0: unsigned.
) (
    input  wire       clk_i,
    input  wire       rstn_i,
    input  wire       soft_rst_i,
    input  wire [7:0] code_i,
    output wire [4:0] step_o
);

    // ------------------------------------------------------------------------
    // Clamp logic.
    // ------------------------------------------------------------------------
    reg  [4:0] step_reg;                    // Applied step count.
    reg  [4:0] step_next;                   // Clamped value of the code.
    wire [7:0] pos_limit;                   // Largest boost code.
    wire [7:0] neg_limit;                   // Deepest cut code.

    // The limits stay a full byte wide so they compare against the code
    // without padding; only their low five bits become a step count.
    assign pos_limit = `DTR_GAIN_POS_MAX;
    assign neg_limit = `DTR_GAIN_NEG_MIN;

    // Codes beyond twelve steps are pulled to the limit, never wrapped, so a
    // careless write cannot turn a large boost into a deep cut.
    always @* begin
        // The low five bits of an in-range code are its step count.
        step_next = code_i[`DTR_STEP_MSB:0];
        if (SIGNED_CODE != 0 && code_i[`DTR_SIGN_BIT]) begin
            // Negative code: cut, limited at minus twelve steps.
            if (code_i < neg_limit) begin
                step_next = neg_limit[`DTR_STEP_MSB:0];
            end
        end else begin
            // Positive or unsigned code: limited at twelve steps.
            if (code_i > pos_limit) begin
                step_next = pos_limit[`DTR_STEP_MSB:0];
            end
        end
    end

    // The step register follows the code one cycle later; both resets clear.
    always @(posedge clk_i) begin
        if (!rstn_i || soft_rst_i) begin
            step_reg <= `DTR_RST_STEP;
        end else begin
            step_reg <= step_next;
        end
    end

    assign step_o = step_reg;

endmodule

// file: dv/dtr_regs_monitor.sv
// Checker of the tone and run register port, bound to dtr_regs.
// Assumes every port is on clk_i with the synchronous reset rstn_i.
`timescale 1ns/1ps
module dtr_regs_monitor (
    input wire        clk_i,
    input wire        rstn_i,
    input wire        soft_rst_i,
    input wire [7:0]  reg_addr_i,
    input wire        reg_wr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    input wire        reg_hit_o,
    input wire        decode_run_o,
    input wire [15:0] treble_corner_o,
    input wire [15:0] bass_corner_o,
    input wire [4:0]  treble_step_o,
    input wire [4:0]  bass_step_o,
    input wire [4:0]  headroom_step_o
);
    // ------------------------------------------------------------------
    // Port relations; a write lost to a soft reset is not expected.
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire wr_ok = reg_wr_i && !soft_rst_i;  // Write that is really taken.

    hit_decode_a: assert property (reg_hit_o == (reg_addr_i inside {8'h6A,
        8'h71, 8'h72, [8'h77:8'h7D]})) else $error("hit flag wrong");
    unmapped_read_a: assert property (reg_rd_i && !reg_hit_o |=>
        reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd_i |=>
        $stable(reg_rdata_o)) else $error("read data moved");
    run_write_a: assert property (wr_ok && reg_addr_i == 8'h72 |=>
        {7'h00, decode_run_o} == ($past(reg_wdata_i) & 8'h01))
        else $error("run flag wrong");
    treble_lo_a: assert property (wr_ok && reg_addr_i == 8'h77 |=>
        treble_corner_o[7:0] == $past(reg_wdata_i))
        else $error("treble corner low byte wrong");
    bass_hi_a: assert property (wr_ok && reg_addr_i == 8'h7A |=>
        bass_corner_o[15:8] == $past(reg_wdata_i))
        else $error("bass corner high byte wrong");
    treble_cap_a: assert property (wr_ok && reg_addr_i == 8'h7B &&
        !reg_wdata_i[7] && reg_wdata_i > 8'h0C ##1 !soft_rst_i
        |=> treble_step_o == 5'h0C) else $error("treble not capped");
    bass_floor_a: assert property (wr_ok && reg_addr_i == 8'h7C &&
        reg_wdata_i[7] && reg_wdata_i < 8'hF4 ##1 !soft_rst_i
        |=> bass_step_o == 5'h14) else $error("bass not floored");
    headroom_cap_a: assert property (wr_ok && reg_addr_i == 8'h7D &&
        reg_wdata_i > 8'h0C ##1 !soft_rst_i
        |=> headroom_step_o == 5'h0C) else $error("headroom not capped");
    soft_clear_a: assert property (soft_rst_i |=> !decode_run_o &&
        treble_corner_o == 16'h0000 && bass_corner_o == 16'h0000 &&
        treble_step_o == 5'h00 && bass_step_o == 5'h00)
        else $error("soft reset left state");
endmodule

bind dtr_regs dtr_regs_monitor i_dtr_regs_monitor (
    .clk_i(clk_i), .rstn_i(rstn_i), .soft_rst_i(soft_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .decode_run_o(decode_run_o), .treble_corner_o(treble_corner_o),
    .bass_corner_o(bass_corner_o), .treble_step_o(treble_step_o),
    .bass_step_o(bass_step_o), .headroom_step_o(headroom_step_o)
);

// file: dv/dtr_host.sv
// Host model: drives the byte register port on falling clock edges.
// Assumes the device takes each strobe at the following rising edge.
`timescale 1ns/1ps
module dtr_host (
    input  wire       clk_i,
    input  wire [7:0] rdata_i,
    output reg  [7:0] addr_o,
    output reg        wr_o,
    output reg  [7:0] wdata_o,
    output reg        rd_o
);
    // Idle port at time zero, so no strobe is seen during reset.
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    // One write: the strobe covers exactly one rising edge.
    task wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(negedge clk_i);
            addr_o = a;
            wdata_o = d;
            wr_o = 1'b1;
            @(negedge clk_i);
            wr_o = 1'b0;
            wdata_o = ~d;  // Stale data is not left on the port.
        end
    endtask
    // One read: data is taken half a cycle after the strobe's edge.
    task rd(input logic [7:0] a, output logic [7:0] d);
        begin
            @(negedge clk_i);
            addr_o = a;
            rd_o = 1'b1;
            @(negedge clk_i);
            rd_o = 1'b0;
            d = rdata_i;
        end
    endtask
endmodule

// file: dv/dtr_regs_tb.sv
// Self-checking bench of dtr_regs through the host model's tasks.
// Assumes the design and its bound checker are compiled alongside.
`timescale 1ns/1ps
module dtr_regs_tb;
    reg         clk_i, rstn_i, soft_rst_i, rate_upd_i, boot_done_i;
    reg  [7:0]  rate_kbps_i, fw_code_i, rd_val;
    wire [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire        reg_wr_i, reg_rd_i, reg_hit_o, decode_run_o;
    wire [15:0] treble_corner_o, bass_corner_o;
    wire [4:0]  treble_step_o, bass_step_o, headroom_step_o;
    integer     n_errors, comparisons, cycles, i;
    localparam [7:0]  FW_CODE = 8'h3C;  // Arbitrary version code.
    localparam [79:0] MAP = 80'h6A_71_72_77_78_79_7A_7B_7C_7D;
    localparam [63:0] CODES = 64'h0C_0D_7F_05_FF_F4_F3_80;
    localparam [127:0] STEPS = 128'h000C_000C_000C_0005_001F_0014_0014_0014;

    dtr_host i_dtr_host (.clk_i(clk_i), .rdata_i(reg_rdata_o),
        .addr_o(reg_addr_i), .wr_o(reg_wr_i), .wdata_o(reg_wdata_i),
        .rd_o(reg_rd_i));
    dtr_regs i_dtr_regs (.clk_i(clk_i), .rstn_i(rstn_i),
        .soft_rst_i(soft_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .reg_hit_o(reg_hit_o), .rate_upd_i(rate_upd_i),
        .rate_kbps_i(rate_kbps_i), .boot_done_i(boot_done_i),
        .fw_code_i(fw_code_i), .decode_run_o(decode_run_o),
        .treble_corner_o(treble_corner_o), .bass_corner_o(bass_corner_o),
        .treble_step_o(treble_step_o), .bass_step_o(bass_step_o),
        .headroom_step_o(headroom_step_o));

    // ------------------------------------------------------------------
    // Comparison, verdict and hang guard.
    // ------------------------------------------------------------------
    task chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        begin
            i_dtr_host.rd(a, rd_val);
            chk({8'h00, rd_val}, {8'h00, exp});
        end
    endtask
    task results;
        begin
            $display("errors=%0d comparisons=%0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // The whole sequence needs well under 400 cycles.
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            results;
        end
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {n_errors, comparisons, cycles} = 96'h0;
        {rstn_i, soft_rst_i, rate_upd_i, boot_done_i} = 4'h0;
        rate_kbps_i = 8'hC0;
        fw_code_i = FW_CODE;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        for (i = 0; i < 10; i = i + 1) rd_chk(MAP[8*i +: 8], 8'h00);
        rd_chk(8'h73, 8'h00);
        chk({15'h0, reg_hit_o}, 16'h0000);
        rate_upd_i = 1'b1;
        boot_done_i = 1'b1;
        @(negedge clk_i);
        {rate_upd_i, boot_done_i} = 2'b00;
        rd_chk(8'h6A, 8'hC0);
        i_dtr_host.wr(8'h6A, 8'h55);
        rd_chk(8'h6A, 8'hC0);
        rd_chk(8'h71, FW_CODE);
        // Headroom first, then corners, then gains, then run.
        i_dtr_host.wr(8'h7D, 8'h05);
        @(negedge clk_i);
        chk({11'h0, headroom_step_o}, 16'h0005);
        i_dtr_host.wr(8'h7D, 8'h0D);
        @(negedge clk_i);
        chk({11'h0, headroom_step_o}, 16'h000C);
        i_dtr_host.wr(8'h78, 8'h0B);
        i_dtr_host.wr(8'h77, 8'hB8);
        chk(treble_corner_o, 16'h0BB8);
        i_dtr_host.wr(8'h7A, 8'h00);
        i_dtr_host.wr(8'h79, 8'hC8);
        chk(bass_corner_o, 16'h00C8);
        for (i = 0; i < 8; i = i + 1) begin
            i_dtr_host.wr(8'h7B, CODES[8*i +: 8]);
            i_dtr_host.wr(8'h7C, CODES[8*i +: 8]);
            @(negedge clk_i);
            chk({11'h0, treble_step_o}, STEPS[16*i +: 16]);
            chk({11'h0, bass_step_o}, STEPS[16*i +: 16]);
            rd_chk(8'h7B, CODES[8*i +: 8]);
        end
        i_dtr_host.wr(8'h72, 8'hFF);
        chk({15'h0, decode_run_o}, 16'h0001);
        rd_chk(8'h72, 8'h01);
        @(negedge clk_i);
        soft_rst_i = 1'b1;
        @(negedge clk_i);
        soft_rst_i = 1'b0;
        chk({15'h0, decode_run_o}, 16'h0000);
        chk({11'h0, treble_step_o}, 16'h0000);
        chk({11'h0, bass_step_o}, 16'h0000);
        chk({11'h0, headroom_step_o}, 16'h0000);
        for (i = 0; i < 10; i = i + 1) rd_chk(MAP[8*i +: 8], 8'h00);
        results;
    end
endmodule
